// *** ssp_cfg.svh ***
// Purpose: Constants for the serial sensor poller
// Assumes: Byte addresses on a 32-bit Avalon-MM slave
// Notes:   Times are clock cycles of clk_i unless named otherwise
`ifndef SSP_CFG_SVH
`define SSP_CFG_SVH

// ---------------------------------------------------------------------
// Clock and line rates
// ---------------------------------------------------------------------
`define SSP_CLK_HZ      250000000
`define SSP_BAUD_0      300
`define SSP_BAUD_1      600
`define SSP_BAUD_2      1200
`define SSP_BAUD_3      2400
`define SSP_BAUD_4      4800
`define SSP_BAUD_5      9600
`define SSP_BAUD_6      19200
`define SSP_BAUD_7      38400
`define SSP_BAUD_8      57600
`define SSP_BAUD_9      115200

// ---------------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------------
`define SSP_ADDR_W      7
`define SSP_OFS_CTRL    7'h00
`define SSP_OFS_TMO     7'h04
`define SSP_OFS_CYCLE   7'h08
`define SSP_OFS_LEN     7'h0c
`define SSP_OFS_STAT    7'h10
`define SSP_OFS_MASK    7'h14
`define SSP_OFS_VALUE   7'h18
`define SSP_OFS_CHAN    7'h1c
`define SSP_SEL_REQ     2'h1
`define SSP_SEL_SP      2'h2
`define SSP_BUF_DEPTH   8

// ---------------------------------------------------------------------
// Control fields
// ---------------------------------------------------------------------
`define SSP_CTRL_EN     0
`define SSP_CTRL_BAUD   4:1
`define SSP_CTRL_STOP2  5
`define SSP_CTRL_PAR    7:6
`define SSP_CTRL_SEVEN  8
`define SSP_CTRL_RETRY  9
`define SSP_CTRL_HOLD   12:10
`define SSP_CTRL_RST    13'h00a
`define SSP_PAR_ODD     2'h1
`define SSP_PAR_EVEN    2'h2
`define SSP_HOLD_OFF    3'h0
`define SSP_HOLD_MAX    3'h5

// ---------------------------------------------------------------------
// Length fields, status bits
// ---------------------------------------------------------------------
`define SSP_LEN_REQ     3:0
`define SSP_LEN_ANS     11:8
`define SSP_LEN_SP      19:16
`define SSP_ST_ERR      0
`define SSP_ST_DONE     1
`define SSP_ST_RETRY    2
`define SSP_ST_CHAR     3
`define SSP_ST_W        4

`endif

// *** ssp_pkg.sv ***
// Purpose: Types shared by the serial sensor poller files
// Assumes: Constants come from ssp_cfg.svh
// Notes:   Nothing here is imported; use ssp_pkg::name
package ssp_pkg;

  // -------------------------------------------------------------------
  // Character framing
  // -------------------------------------------------------------------
  typedef struct packed {
    logic seven;
    logic par_en;
    logic par_odd;
    logic two_stop;
  } ssp_frame_t;

  // -------------------------------------------------------------------
  // State machines
  // -------------------------------------------------------------------
  typedef enum logic [1:0] {
    SSP_IDLE,
    SSP_REQ,
    SSP_WAIT,
    SSP_SETP
  } ssp_seq_t;

  typedef enum logic [2:0] {
    SSP_RX_IDLE,
    SSP_RX_START,
    SSP_RX_DATA,
    SSP_RX_PAR,
    SSP_RX_STOP
  } ssp_rx_t;

endpackage : ssp_pkg

// *** ssp_tx.sv ***
// Purpose: One-character serial transmitter
// Assumes: start_i only while busy_o is low
// Notes:   Frame is built whole at start and shifted out LSB first
`timescale 1ns/1ps
module ssp_tx #(
  parameter int DIV_W = 20
) (
  input  wire logic               clk_i,
  input  wire logic               rst_b_i,
  input  wire logic [DIV_W-1:0]   div_i,
  input  wire ssp_pkg::ssp_frame_t frame_i,
  input  wire logic               start_i,
  input  wire logic [7:0]         data_i,
  output logic                    busy_o,
  output logic                    txd_o
);

  logic [11:0]      sh_q;
  logic [3:0]       left_q;
  logic [DIV_W-1:0] cnt_q;
  logic [7:0]       dat;
  logic             par;
  logic [3:0]       nbits;

  always_comb begin
    dat   = frame_i.seven ? {1'b0, data_i[6:0]} : data_i;
    par   = (^dat) ^ frame_i.par_odd;
    nbits = 4'd1 + (frame_i.seven ? 4'd7 : 4'd8)
          + {3'd0, frame_i.par_en} + (frame_i.two_stop ? 4'd2 : 4'd1);
  end

  // -------------------------------------------------------------------
  // Shifter
  // -------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      sh_q   <= 12'hfff;
      left_q <= 4'h0;
      cnt_q  <= '0;
      busy_o <= 1'b0;
      txd_o  <= 1'b1;
    end else if (start_i && !busy_o) begin
      // Start low, data LSB first, parity, stops high
      if (frame_i.seven) begin
        sh_q <= frame_i.par_en ? {3'b111, par, dat[6:0], 1'b0}  // R17 R3
                               : {4'b1111, dat[6:0], 1'b0};     // R4
      end else begin
        sh_q <= frame_i.par_en ? {2'b11, par, dat, 1'b0}        // R3
                               : {3'b111, dat, 1'b0};           // R17
      end
      left_q <= nbits;                                          // R2
      cnt_q  <= div_i;
      busy_o <= 1'b1;
      txd_o  <= 1'b1;
    end else if (busy_o) begin
      txd_o <= sh_q[0];
      if (cnt_q == div_i) begin
        cnt_q <= '0;
        if (left_q == 4'h0) begin
          busy_o <= 1'b0;
          txd_o  <= 1'b1;
        end else begin
          txd_o  <= sh_q[0];
          sh_q   <= {1'b1, sh_q[11:1]};
          left_q <= left_q - 4'h1;
        end
      end else begin
        cnt_q <= cnt_q + 1'b1;
        txd_o <= txd_o;
      end
    end
  end

endmodule : ssp_tx

// *** ssp_top.sv ***
// Purpose: Serial sensor poller with Avalon-MM register access
// Assumes: rxd_i is synchronous to clk_i
// Notes:   Overview of the polling flow below
//
// Overview of operation
// R1 - Ten selectable line rates, 300 to 115200
// R2 - One or two stop bits
// R3 - Parity none, odd or even, generated and checked
// R4 - Seven or eight data bits
// R5 - Send request sequence at each measurement instant
// R6 - Sensor answers fully within frame timeout
// R7 - Missing answer at timeout is communication error
// R8 - Retry resends request once, restarts timeout
// R9 - With retry, error only if both fail
// R10 - Error puts open-loop value on channel
// R11 - Setpoint record sent after every exchange
// R12 - Hold count keeps last value N cycles
// R13 - Hold on keeps last value until valid
// R14 - Timeout, doubled with retry, below cycle
// R15 - Zero timeout disables timeout supervision
// R16 - Port off: no traffic, no errors
// R17 - Start low, data LSB first, parity, stops
//
// Design decisions made here: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
`include "ssp_cfg.svh"
module ssp_top #(
  parameter int DIV_W = 20
) (
  input  wire logic                   clk_i,
  input  wire logic                   rst_b_i,
  input  wire logic [`SSP_ADDR_W-1:0] avs_address_i,
  input  wire logic                   avs_read_i,
  input  wire logic                   avs_write_i,
  input  wire logic [31:0]            avs_writedata_i,
  output logic      [31:0]            avs_readdata_o,
  output logic                        avs_waitrequest_o,
  input  wire logic                   rxd_i,
  output logic                        txd_o,
  output logic      [31:0]            chan_value_o,
  output logic                        chan_open_loop_o,
  output logic                        irq_o
);

  if (DIV_W < 20 || DIV_W > 32) begin : g_div_chk
    $error("ssp_top: DIV_W must be 20 to 32");
  end

  // -------------------------------------------------------------------
  // Registers
  // -------------------------------------------------------------------
  logic [12:0]             ctrl_q;
  logic [31:0]             tmo_q;
  logic [31:0]             cycle_q;
  logic [19:0]             len_q;
  logic [`SSP_ST_W-1:0]    stat_q;
  logic [`SSP_ST_W-1:0]    mask_q;
  logic [`SSP_ST_W-1:0]    stat_set;
  logic [7:0]              req_mem [`SSP_BUF_DEPTH];
  logic [7:0]              sp_mem  [`SSP_BUF_DEPTH];
  logic                    wr_hit;
  logic                    rd_hit;
  logic [`SSP_ADDR_W-1:0]  a;
  logic                    en;
  ssp_pkg::ssp_frame_t     frame;
  logic [DIV_W-1:0]        div_q;
  ssp_pkg::ssp_seq_t       seq_q;

  assign a      = avs_address_i;
  assign wr_hit = avs_write_i && !avs_waitrequest_o;
  assign rd_hit = avs_read_i && avs_waitrequest_o;
  assign en     = ctrl_q[`SSP_CTRL_EN];

  always_comb begin
    frame.seven    = ctrl_q[`SSP_CTRL_SEVEN];                   // R4
    frame.par_en   = ctrl_q[`SSP_CTRL_PAR] == `SSP_PAR_ODD
                  || ctrl_q[`SSP_CTRL_PAR] == `SSP_PAR_EVEN;    // R3
    frame.par_odd  = ctrl_q[`SSP_CTRL_PAR] == `SSP_PAR_ODD;
    frame.two_stop = ctrl_q[`SSP_CTRL_STOP2];                   // R2
  end

  // Divisor from baud select; unknown selects fall back to the slowest
  function automatic logic [DIV_W-1:0] baud_div(input logic [3:0] sel);
    int baud;
    baud = `SSP_BAUD_0;
    case (sel)
      4'h1:    baud = `SSP_BAUD_1;
      4'h2:    baud = `SSP_BAUD_2;
      4'h3:    baud = `SSP_BAUD_3;
      4'h4:    baud = `SSP_BAUD_4;
      4'h5:    baud = `SSP_BAUD_5;
      4'h6:    baud = `SSP_BAUD_6;
      4'h7:    baud = `SSP_BAUD_7;
      4'h8:    baud = `SSP_BAUD_8;
      4'h9:    baud = `SSP_BAUD_9;
      default: baud = `SSP_BAUD_0;
    endcase
    return DIV_W'(`SSP_CLK_HZ / baud - 1);
  endfunction : baud_div

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      div_q <= '0;
    end else begin
      div_q <= baud_div(ctrl_q[`SSP_CTRL_BAUD]);                // R1
    end
  end

  // -------------------------------------------------------------------
  // Avalon-MM slave: one wait cycle, then answer
  // -------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      avs_waitrequest_o <= 1'b1;
    end else begin
      avs_waitrequest_o <= !((avs_read_i || avs_write_i)
                             && avs_waitrequest_o);
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      avs_readdata_o <= 32'h0;
    end else if (rd_hit) begin
      if (a == `SSP_OFS_CTRL) begin
        avs_readdata_o <= {19'h0, ctrl_q};
      end else if (a == `SSP_OFS_TMO) begin
        avs_readdata_o <= tmo_q;
      end else if (a == `SSP_OFS_CYCLE) begin
        avs_readdata_o <= cycle_q;
      end else if (a == `SSP_OFS_LEN) begin
        avs_readdata_o <= {12'h0, len_q};
      end else if (a == `SSP_OFS_STAT) begin
        avs_readdata_o <= {28'h0, stat_q};
      end else if (a == `SSP_OFS_MASK) begin
        avs_readdata_o <= {28'h0, mask_q};
      end else if (a == `SSP_OFS_VALUE) begin
        avs_readdata_o <= chan_value_o;
      end else if (a == `SSP_OFS_CHAN) begin
        avs_readdata_o <= {30'h0, seq_q != ssp_pkg::SSP_IDLE,
                           chan_open_loop_o};
      end else if (a[6:5] == `SSP_SEL_REQ) begin
        avs_readdata_o <= {24'h0, req_mem[a[4:2]]};
      end else if (a[6:5] == `SSP_SEL_SP) begin
        avs_readdata_o <= {24'h0, sp_mem[a[4:2]]};
      end else begin
        avs_readdata_o <= 32'h0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      ctrl_q  <= `SSP_CTRL_RST;
      tmo_q   <= 32'h0;
      cycle_q <= 32'h0;
      len_q   <= 20'h0;
      mask_q  <= '0;
    end else if (wr_hit) begin
      if (a == `SSP_OFS_CTRL) begin
        ctrl_q <= avs_writedata_i[12:0];
      end else if (a == `SSP_OFS_TMO) begin
        tmo_q <= avs_writedata_i;       // Keep below cycle, halved w/ retry
      end else if (a == `SSP_OFS_CYCLE) begin
        cycle_q <= avs_writedata_i;
      end else if (a == `SSP_OFS_LEN) begin
        len_q <= avs_writedata_i[19:0];
      end else if (a == `SSP_OFS_MASK) begin
        mask_q <= avs_writedata_i[`SSP_ST_W-1:0];
      end
    end
  end

  // Buffers have no reset; software loads them before enabling
  always_ff @(posedge clk_i) begin
    if (wr_hit && a[6:5] == `SSP_SEL_REQ) begin
      req_mem[a[4:2]] <= avs_writedata_i[7:0];
    end
    if (wr_hit && a[6:5] == `SSP_SEL_SP) begin
      sp_mem[a[4:2]] <= avs_writedata_i[7:0];
    end
  end

  // Set wins over a simultaneous write-one clear
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      stat_q <= '0;
      irq_o  <= 1'b0;
    end else begin
      stat_q <= (stat_q & ~((wr_hit && a == `SSP_OFS_STAT)
                ? avs_writedata_i[`SSP_ST_W-1:0] : '0)) | stat_set;
      irq_o  <= |(stat_q & mask_q);
    end
  end

  // -------------------------------------------------------------------
  // Measurement timer
  // -------------------------------------------------------------------
  logic [31:0] cyc_cnt_q;
  logic        meas_q;

  always_ff @(posedge clk_i) begin
    if (!rst_b_i || !en || cycle_q == 32'h0) begin
      cyc_cnt_q <= 32'h0;
      meas_q    <= 1'b0;
    end else if (cyc_cnt_q >= cycle_q - 32'h1) begin
      cyc_cnt_q <= 32'h0;
      meas_q    <= 1'b1;
    end else begin
      cyc_cnt_q <= cyc_cnt_q + 32'h1;
      meas_q    <= 1'b0;
    end
  end

  // -------------------------------------------------------------------
  // Receiver, live only while an answer is awaited
  // -------------------------------------------------------------------
  ssp_pkg::ssp_rx_t rx_q;
  logic [DIV_W-1:0] rx_cnt_q;
  logic [3:0]       rx_bit_q;
  logic [7:0]       rx_sh_q;
  logic             rx_par_q;
  logic             rx_byte_q;
  logic             rx_bad_q;
  logic             rx_tick;
  logic             rx_on;

  assign rx_tick = rx_cnt_q == div_q;
  assign rx_on   = en && seq_q == ssp_pkg::SSP_WAIT;            // R16

  always_ff @(posedge clk_i) begin
    if (!rst_b_i || !rx_on) begin
      rx_q      <= ssp_pkg::SSP_RX_IDLE;
      rx_cnt_q  <= '0;
      rx_bit_q  <= 4'h0;
      rx_sh_q   <= 8'h0;
      rx_par_q  <= 1'b0;
      rx_byte_q <= 1'b0;
      rx_bad_q  <= 1'b0;
    end else begin
      rx_byte_q <= 1'b0;
      rx_bad_q  <= 1'b0;
      rx_cnt_q  <= rx_tick ? '0 : rx_cnt_q + 1'b1;
      case (rx_q)
        ssp_pkg::SSP_RX_IDLE: begin
          rx_cnt_q <= {1'b0, div_q[DIV_W-1:1]};   // Half bit to centre
          if (!rxd_i) begin
            rx_q <= ssp_pkg::SSP_RX_START;
          end
        end
        ssp_pkg::SSP_RX_START: begin
          if (rx_tick) begin
            rx_q     <= rxd_i ? ssp_pkg::SSP_RX_IDLE                // R17
                              : ssp_pkg::SSP_RX_DATA;
            rx_bit_q <= 4'h0;
            rx_par_q <= frame.par_odd;
          end
        end
        ssp_pkg::SSP_RX_DATA: begin
          if (rx_tick) begin
            rx_sh_q  <= {rxd_i, rx_sh_q[7:1]};                     // R17
            rx_par_q <= rx_par_q ^ rxd_i;
            rx_bit_q <= rx_bit_q + 4'h1;
            if (rx_bit_q == (frame.seven ? 4'h6 : 4'h7)) begin      // R4
              rx_q <= frame.par_en ? ssp_pkg::SSP_RX_PAR
                                   : ssp_pkg::SSP_RX_STOP;
            end
          end
        end
        ssp_pkg::SSP_RX_PAR: begin
          if (rx_tick) begin
            rx_par_q <= rx_par_q ^ rxd_i;                           // R3
            rx_q     <= ssp_pkg::SSP_RX_STOP;
          end
        end
        default: begin
          // Only the first stop bit is checked; a second one is idle
          if (rx_tick) begin
            if (frame.seven) begin
              rx_sh_q <= {1'b0, rx_sh_q[7:1]};
            end
            rx_byte_q <= 1'b1;
            rx_bad_q  <= !rxd_i || (frame.par_en && rx_par_q);      // R3
            rx_q      <= ssp_pkg::SSP_RX_IDLE;
          end
        end
      endcase
    end
  end

  // -------------------------------------------------------------------
  // Poll sequencer
  // -------------------------------------------------------------------
  logic [3:0]  idx_q;
  logic [3:0]  ans_cnt_q;
  logic [31:0] ans_q;
  logic [31:0] tmo_cnt_q;
  logic        retried_q;
  logic        tx_start_q;
  logic [7:0]  tx_data_q;
  logic        tx_busy;
  logic        tx_ready;
  logic        ok_q;
  logic        fail_q;
  logic        tmo_hit;

  assign tx_ready = !tx_busy && !tx_start_q;
  assign tmo_hit  = tmo_q != 32'h0 && tmo_cnt_q >= tmo_q;       // R15

  always_ff @(posedge clk_i) begin
    if (!rst_b_i || !en) begin                                  // R16
      seq_q      <= ssp_pkg::SSP_IDLE;
      idx_q      <= 4'h0;
      ans_cnt_q  <= 4'h0;
      ans_q      <= 32'h0;
      tmo_cnt_q  <= 32'h0;
      retried_q  <= 1'b0;
      tx_start_q <= 1'b0;
      tx_data_q  <= 8'h0;
      ok_q       <= 1'b0;
      fail_q     <= 1'b0;
      stat_set   <= '0;
    end else begin
      tx_start_q <= 1'b0;
      ok_q       <= 1'b0;
      fail_q     <= 1'b0;
      stat_set   <= '0;
      stat_set[`SSP_ST_CHAR] <= rx_byte_q && rx_bad_q;
      case (seq_q)
        ssp_pkg::SSP_IDLE: begin
          if (meas_q) begin
            seq_q     <= ssp_pkg::SSP_REQ;                          // R5
            idx_q     <= 4'h0;
            retried_q <= 1'b0;
          end
        end
        ssp_pkg::SSP_REQ: begin
          if (tx_ready && idx_q == len_q[`SSP_LEN_REQ]) begin
            seq_q     <= ssp_pkg::SSP_WAIT;
            tmo_cnt_q <= 32'h0;
            ans_cnt_q <= 4'h0;
          end else if (tx_ready) begin
            tx_start_q <= 1'b1;
            tx_data_q  <= req_mem[idx_q[2:0]];
            idx_q      <= idx_q + 4'h1;
          end
        end
        ssp_pkg::SSP_WAIT: begin
          tmo_cnt_q <= tmo_cnt_q + 32'h1;
          if (rx_byte_q) begin
            ans_q     <= {ans_q[23:0], rx_sh_q};
            ans_cnt_q <= ans_cnt_q + 4'h1;
          end
          if (ans_cnt_q == len_q[`SSP_LEN_ANS]) begin
            ok_q  <= 1'b1;
            seq_q <= ssp_pkg::SSP_SETP;
            idx_q <= 4'h0;
          end else if (tmo_hit && ctrl_q[`SSP_CTRL_RETRY]
                       && !retried_q) begin
            retried_q <= 1'b1;                                      // R8
            stat_set[`SSP_ST_RETRY] <= 1'b1;
            seq_q     <= ssp_pkg::SSP_REQ;
            idx_q     <= 4'h0;
          end else if (tmo_hit) begin
            fail_q  <= 1'b1;                                        // R7 R9
            stat_set[`SSP_ST_ERR] <= 1'b1;
            seq_q   <= ssp_pkg::SSP_SETP;                           // R11
            idx_q   <= 4'h0;
          end else if (meas_q && tmo_q == 32'h0) begin
            // No supervision: give up quietly at the next instant
            seq_q <= ssp_pkg::SSP_SETP;                             // R15
            idx_q <= 4'h0;
          end
        end
        default: begin
          if (tx_ready && idx_q == len_q[`SSP_LEN_SP]) begin
            seq_q <= ssp_pkg::SSP_IDLE;
            stat_set[`SSP_ST_DONE] <= 1'b1;
          end else if (tx_ready) begin
            tx_start_q <= 1'b1;                                     // R11
            tx_data_q  <= sp_mem[idx_q[2:0]];
            idx_q      <= idx_q + 4'h1;
          end
        end
      endcase
    end
  end

  // -------------------------------------------------------------------
  // Channel value with hold
  // -------------------------------------------------------------------
  logic [2:0] held_q;
  logic [2:0] hold;

  assign hold = ctrl_q[`SSP_CTRL_HOLD];

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      chan_value_o     <= 32'h0;
      chan_open_loop_o <= 1'b0;
      held_q           <= 3'h0;
    end else if (ok_q) begin
      chan_value_o     <= ans_q;
      chan_open_loop_o <= 1'b0;
      held_q           <= 3'h0;
    end else if (fail_q) begin
      if (hold == `SSP_HOLD_OFF) begin
        chan_open_loop_o <= 1'b1;                                   // R10
      end else if (hold <= `SSP_HOLD_MAX) begin
        if (held_q >= hold) begin
          chan_open_loop_o <= 1'b1;                                 // R12
        end else begin
          held_q <= held_q + 3'h1;                                  // R12
        end
      end else begin
        chan_open_loop_o <= chan_open_loop_o;                       // R13
      end
    end
  end

  ssp_tx #(
    .DIV_W (DIV_W)
  ) u_tx (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i && en),
    .div_i   (div_q),
    .frame_i (frame),
    .start_i (tx_start_q),
    .data_i  (tx_data_q),
    .busy_o  (tx_busy),
    .txd_o   (txd_o)
  );

endmodule : ssp_top

// *** ssp_monitor.sv ***
// Purpose: Port checker for the serial sensor poller
// Assumes: Tracks enable and mask from completed bus writes
// Notes:   Bound to ssp_top below the module
`timescale 1ns/1ps
`include "ssp_cfg.svh"
module ssp_monitor #(
  parameter int DIV_W = 20
) (
  input wire logic                   clk_i,
  input wire logic                   rst_b_i,
  input wire logic [`SSP_ADDR_W-1:0] avs_address_i,
  input wire logic                   avs_read_i,
  input wire logic                   avs_write_i,
  input wire logic [31:0]            avs_writedata_i,
  input wire logic [31:0]            avs_readdata_o,
  input wire logic                   avs_waitrequest_o,
  input wire logic                   txd_o,
  input wire logic [31:0]            chan_value_o,
  input wire logic                   chan_open_loop_o,
  input wire logic                   irq_o
);
  logic       en_q;
  logic [3:0] mask_q;

  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  // Shadow of enable and mask, taken where the write lands
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      en_q   <= 1'b0;
      mask_q <= 4'h0;
    end else if (avs_write_i && !avs_waitrequest_o) begin
      if (avs_address_i == `SSP_OFS_CTRL) en_q <= avs_writedata_i[0];
      if (avs_address_i == `SSP_OFS_MASK) mask_q <= avs_writedata_i[3:0];
    end
  end

  sequence s_req;
    (avs_read_i || avs_write_i) && avs_waitrequest_o;
  endsequence
  sequence s_ans;
    !avs_waitrequest_o ##1 avs_waitrequest_o;
  endsequence

  property p_ans; s_req |=> s_ans; endproperty
  a_ans: assert property (p_ans) else $error("bus answer late");
  property p_one; !avs_waitrequest_o |=> avs_waitrequest_o; endproperty
  a_one: assert property (p_one) else $error("waitrequest low too long");
  property p_unmap;
    avs_read_i && !avs_waitrequest_o && avs_address_i >= 7'h60
      |-> avs_readdata_o == 32'h0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_rdst; !$past(avs_read_i) |-> $stable(avs_readdata_o); endproperty
  a_rdst: assert property (p_rdst) else $error("read data moved");
  property p_rst;
    $rose(rst_b_i) |-> avs_waitrequest_o && txd_o && !irq_o
      && !chan_open_loop_o && chan_value_o == 32'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("bad reset outputs");
  property p_start; $fell(txd_o) |-> !txd_o [*8]; endproperty
  a_start: assert property (p_start) else $error("start bit too short");
  property p_off; !en_q [*4] |-> txd_o; endproperty
  a_off: assert property (p_off) else $error("traffic while off");
  property p_irq; mask_q == 4'h0 [*3] |-> !irq_o; endproperty
  a_irq: assert property (p_irq) else $error("masked interrupt seen");
endmodule : ssp_monitor

bind ssp_top ssp_monitor #(.DIV_W(DIV_W)) u_mon (
  .clk_i(clk_i), .rst_b_i(rst_b_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .txd_o(txd_o),
  .chan_value_o(chan_value_o), .chan_open_loop_o(chan_open_loop_o),
  .irq_o(irq_o));

// *** ssp_sensor.sv ***
// Purpose: Digital sensor model on the serial line
// Assumes: Seven data bits, no parity, one stop bit
// Notes:   Answers one byte after each received character when told to
`timescale 1ns/1ps
module ssp_sensor #(
  parameter int BIT = 2170
) (
  input  wire logic       clk_i,
  input  wire logic       txd_i,
  input  wire logic       answer_i,
  input  wire logic [7:0] data_i,
  output logic            rxd_o,
  output int              reqs_o
);
  initial begin
    rxd_o  = 1'b1;
    reqs_o = 0;
  end

  // Idle mark level is high, so the line rests there between frames
  always begin
    @(negedge txd_i);
    reqs_o <= reqs_o + 1;
    repeat (9 * BIT) @(posedge clk_i);
    if (answer_i) begin
      for (int i = -1; i < 8; i++) begin
        rxd_o <= (i < 0) ? 1'b0 : (i < 7) ? data_i[i] : 1'b1;
        repeat (BIT) @(posedge clk_i);
      end
    end
  end
endmodule : ssp_sensor

// *** test_serial_sensor_poller.sv ***
// Purpose: Self-checking bench for the serial sensor poller
// Assumes: Line rate 115200, seven data bits, no parity, one stop bit
// Notes:   Mute sensor with retry first, then a clean exchange
`timescale 1ns/1ps
`include "ssp_cfg.svh"
module test_serial_sensor_poller;
  logic [`SSP_ADDR_W-1:0] avs_address_i;
  logic [31:0]            avs_writedata_i;
  logic [31:0]            avs_readdata_o;
  logic [31:0]            chan_value_o;
  logic [31:0]            q;
  logic clk_i, rst_b_i, avs_read_i, avs_write_i, avs_waitrequest_o;
  logic rxd_i, txd_o, chan_open_loop_o, irq_o, answer_q;
  int   reqs, seen, failures, checks, cycles;

  ssp_top DUT (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .rxd_i(rxd_i), .txd_o(txd_o), .chan_value_o(chan_value_o),
    .chan_open_loop_o(chan_open_loop_o), .irq_o(irq_o));
  ssp_sensor #(.BIT(2170)) u_sensor (.clk_i(clk_i), .txd_i(txd_o),
    .answer_i(answer_q), .data_i(8'h5a), .rxd_o(rxd_i), .reqs_o(reqs));

  initial clk_i = 1'b0;
  always #2 clk_i = ~clk_i;

  task automatic bus(input logic w, input logic [6:0] a, input logic [31:0] d);
    @(posedge clk_i);
    avs_address_i   <= a;
    avs_writedata_i <= d;
    avs_write_i     <= w;
    avs_read_i      <= !w;
    do begin
      @(posedge clk_i);
    end while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
  endtask : bus

  task automatic chk(input string n, input logic [31:0] e, g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic rchk(input logic [6:0] a, input logic [31:0] m,
                      input logic [31:0] e, input string n);
    bus(1'b0, a, 32'h0);
    chk(n, e, q & m);
  endtask : rchk

  task automatic poll(input int b);
    do begin
      bus(1'b0, `SSP_OFS_STAT, 32'h0);
    end while (q[b] !== 1'b1);
  endtask : poll

  task automatic tally_and_finish;
    if (failures == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : tally_and_finish

  // Hang guard, about 30 percent above the expected run
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 130000) begin
      failures++;
      tally_and_finish();
    end
  end

  initial begin
    {rst_b_i, avs_read_i, avs_write_i, answer_q} = 4'h0;
    avs_address_i   = 7'h00;
    avs_writedata_i = 32'h0;
    {failures, checks, cycles} = {32'h0, 32'h0, 32'h0};
    repeat (10) @(posedge clk_i);
    rst_b_i <= 1'b1;
    rchk(`SSP_OFS_CTRL, 32'h1fff, 32'h00a, "ctrl reset");
    rchk(`SSP_OFS_STAT, 32'hf, 32'h0, "status reset");
    bus(1'b1, 7'h60, 32'hffff_ffff);
    rchk(7'h60, 32'hffff_ffff, 32'h0, "unmapped");
    // Mute sensor with retry; short timeout keeps the run brief
    bus(1'b1, `SSP_OFS_TMO, 32'h64);
    bus(1'b1, `SSP_OFS_CYCLE, 32'h3e8);
    bus(1'b1, `SSP_OFS_LEN, 32'h101);
    bus(1'b1, 7'h20, 32'h3c);
    bus(1'b1, `SSP_OFS_MASK, 32'h1);
    bus(1'b1, `SSP_OFS_CTRL, 32'h313);
    poll(`SSP_ST_ERR);
    poll(`SSP_ST_DONE);
    chk("requests", 32'h2, 32'(reqs));
    chk("open loop", 32'h1, 32'(chan_open_loop_o));
    chk("irq", 32'h1, 32'(irq_o));
    rchk(`SSP_OFS_STAT, 32'hf, 32'h7, "error status");
    bus(1'b1, `SSP_OFS_CTRL, 32'h312);
    bus(1'b1, `SSP_OFS_STAT, 32'hf);
    seen = reqs;
    repeat (2000) @(posedge clk_i);
    chk("irq cleared", 32'h0, 32'(irq_o));
    chk("requests off", 32'(seen), 32'(reqs));
    rchk(`SSP_OFS_STAT, 32'hf, 32'h0, "status cleared");
    // Answering sensor, no retry
    answer_q <= 1'b1;
    bus(1'b1, `SSP_OFS_TMO, 32'h4e20);
    bus(1'b1, `SSP_OFS_CYCLE, 32'h4e21);
    bus(1'b1, `SSP_OFS_CTRL, 32'h113);
    poll(`SSP_ST_DONE);
    rchk(`SSP_OFS_STAT, 32'hf, 32'h2, "clean status");
    rchk(`SSP_OFS_VALUE, 32'hff, 32'h5a, "answer byte");
    chk("value pin", 32'h5a, chan_value_o);
    chk("open loop", 32'h0, 32'(chan_open_loop_o));
    chk("requests", 32'(seen + 1), 32'(reqs));
    tally_and_finish();
  end
endmodule : test_serial_sensor_poller
